// ### design/tcp_regs.sv
// Configuration, sector write-lock and control registers of the tag,
// plus the open-drain RF activity output and the harvest enable.
// Assumes the I2C and RF engines on the same clock, and a power-on reset.
// Notes on behaviour
// - Write-lock area at byte 2048, reached only with chip enable select bit 1.
// - Low four lock bits block I2C writes to sectors 0-3; upper ignored.
// - Lock area always readable; writable only after I2C password accepted.
// - Both lock bytes are zero on delivery.
// - Config byte at 2320: bit3 mode, bit2 harvest default, bits1-0 sink.
// - Control at 2336: bit7 write done, bit1 field, bit0 harvest on.
// - Busy mode: activity low from RF start of frame until command done.
// - Busy mode, bad command: low from start of frame until CRC only.
// - Field loss while held low releases the activity output.
// - Busy mode: activity released while any I2C command executes.
// - WIP mode: low only during internal RF write; released in any I2C command.
// - Harvest off when disabled, power too low or current too high.
// - Harvest-on 1 enables harvest delivery, 0 keeps it off.
// - Write-done cleared at reset and write start, set on good completion.
// - At power-up harvest-on loads the inverse of the harvest default bit.
// - Field-present follows whether RF power suffices for commands.
// - RF reads of control return field-present as 1.
// - Config byte I2C read and write need no password, chip enable 1.
// - RF read-config, write-harvest bits 2-0, write-output bit 3.
// - Config writes take effect immediately from either interface.
// - Control register always I2C accessible with chip enable select 1.
// - RF read-control returns control bits; set-harvest writes harvest-on.
// - RF reads return write done 0; bits 6-2 read 0.
`default_nettype none
module tcp_regs
  import tcp_pkg::*;
#(
  parameter logic [7:0] CONFIG_INIT = TCP_CONFIG_DELIVERY
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire tcp_i2c_req_s i2c_req,
  input wire logic i2c_password_ok,
  input wire logic i2c_cmd_active,
  input wire logic [8:0] i2c_mem_addr,
  input wire logic i2c_mem_write,
  output logic i2c_mem_write_allow,
  output logic [7:0] i2c_rdata_q,
  output logic i2c_ack,
  input wire tcp_rf_req_s rf_req,
  output logic [7:0] rf_rdata_q,
  input wire logic rf_sof,
  input wire logic rf_crc_done,
  input wire logic rf_cmd_bad,
  input wire logic rf_cmd_done,
  input wire logic rf_write_start,
  input wire logic rf_answer_start,
  input wire logic write_cycle_start,
  input wire logic write_cycle_ok,
  input wire logic rf_field_pin,
  input wire logic power_ok_pin,
  input wire logic current_ok_pin,
  output logic rf_activity_output_o,
  output logic rf_activity_output_oe,
  output logic harvest_out_en,
  output logic [1:0] sink_level,
  output logic [7:0] config_q,
  output logic [15:0] wlock_q
);
  logic field_s;
  logic power_s;
  logic current_s;
  logic control_hon_q;
  logic done_q;
  logic init_q;
  tcp_act_e act_q;
  tcp_act_e act_d;
  logic sel_wlock_lo;
  logic sel_wlock_hi;
  logic sel_config;
  logic sel_control;
  logic i2c_wr;
  logic [7:0] control_view;
  logic [1:0] sector_idx;

  tcp_sync2 u_sync_field (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(rf_field_pin),
    .sync_out(field_s)
  );
  tcp_sync2 u_sync_power (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(power_ok_pin),
    .sync_out(power_s)
  );
  tcp_sync2 u_sync_current (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(current_ok_pin),
    .sync_out(current_s)
  );

  // Address decode; every system register needs the chip enable select bit
  always_comb begin
    sel_wlock_lo = 1'b0;
    sel_wlock_hi = 1'b0;
    sel_config = 1'b0;
    sel_control = 1'b0;
    if (!i2c_req.chip_enable_select_bit) begin
      sel_wlock_lo = 1'b0;
    end else if (i2c_req.addr == TCP_ADDR_WLOCK_LO) begin
      sel_wlock_lo = 1'b1;
    end else if (i2c_req.addr == TCP_ADDR_WLOCK_HI) begin
      sel_wlock_hi = 1'b1;
    end else if (i2c_req.addr == TCP_ADDR_CONFIG) begin
      sel_config = 1'b1;
    end else if (i2c_req.addr == TCP_ADDR_CONTROL) begin
      sel_control = 1'b1;
    end
  end

  assign i2c_wr = i2c_req.valid && i2c_req.write;
  assign i2c_ack = i2c_req.valid && (sel_wlock_lo || sel_wlock_hi || sel_config || sel_control);

  // Write lock; password only gates writes, never reads
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wlock_q <= TCP_WLOCK_RESET;
    end else if (i2c_wr && i2c_password_ok) begin
      if (sel_wlock_lo) begin
        wlock_q[7:0] <= i2c_req.wdata;
      end else if (sel_wlock_hi) begin
        wlock_q[15:8] <= i2c_req.wdata;
      end
    end
  end

  // Sector of a user memory byte is the top bits of the 9-bit address
  assign sector_idx = i2c_mem_addr[8:7];
  assign i2c_mem_write_allow = i2c_mem_write && !wlock_q[sector_idx];

  // Config byte stands in for the non-volatile cell; mode is read live
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      config_q <= CONFIG_INIT;
    end else if (i2c_wr && sel_config) begin
      config_q <= i2c_req.wdata;
    end else if (rf_req.valid && rf_req.cmd == TCP_RF_WRITE_HARVEST) begin
      config_q <= (config_q & ~TCP_HARV_CFG_MASK) | (rf_req.wdata & TCP_HARV_CFG_MASK);
    end else if (rf_req.valid && rf_req.cmd == TCP_RF_WRITE_OUTPUT) begin
      config_q <= (config_q & ~TCP_MODE_CFG_MASK) | (rf_req.wdata & TCP_MODE_CFG_MASK);
    end
  end
  assign sink_level = config_q[1:0];

  // Harvest-on loaded once after reset release from the stored default
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      init_q <= 1'b1;
      control_hon_q <= 1'b0;
    end else if (init_q) begin
      init_q <= 1'b0;
      control_hon_q <= ~config_q[TCP_CFG_HDEF_BIT];
    end else if (i2c_wr && sel_control) begin
      control_hon_q <= i2c_req.wdata[TCP_CTL_HON_BIT];
    end else if (rf_req.valid && rf_req.cmd == TCP_RF_SET_HARVEST) begin
      control_hon_q <= rf_req.wdata[TCP_CTL_HON_BIT];
    end
  end

  // Start wins over a completion in the same cycle: a new write is pending
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (write_cycle_start) begin
      done_q <= 1'b0;
    end else if (write_cycle_ok) begin
      done_q <= 1'b1;
    end
  end

  always_comb begin
    control_view = 8'h00;
    control_view[TCP_CTL_DONE_BIT] = done_q;
    control_view[TCP_CTL_FIELD_BIT] = field_s;
    control_view[TCP_CTL_HON_BIT] = control_hon_q;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      i2c_rdata_q <= 8'h00;
    end else if (i2c_req.valid && !i2c_req.write) begin
      if (sel_wlock_lo) begin
        i2c_rdata_q <= wlock_q[7:0];
      end else if (sel_wlock_hi) begin
        i2c_rdata_q <= wlock_q[15:8];
      end else if (sel_config) begin
        i2c_rdata_q <= config_q;
      end else if (sel_control) begin
        i2c_rdata_q <= control_view;
      end else begin
        i2c_rdata_q <= 8'h00;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rf_rdata_q <= 8'h00;
    end else if (rf_req.valid && rf_req.cmd == TCP_RF_READ_CONFIG) begin
      rf_rdata_q <= config_q;
    end else if (rf_req.valid && rf_req.cmd == TCP_RF_READ_CONTROL) begin
      // Field is on by definition while RF reads; write done hidden
      rf_rdata_q <= {1'b0, control_view[6:2], 1'b1, control_hon_q};
    end
  end

  // Activity tracking: busy from SOF, or WIP during internal RF write
  always_comb begin
    act_d = act_q;
    case (act_q)
      TCP_ACT_IDLE: begin
        if (!config_q[TCP_CFG_MODE_BIT] && rf_sof) begin
          act_d = TCP_ACT_BUSY;
        end else if (config_q[TCP_CFG_MODE_BIT] && rf_write_start) begin
          act_d = TCP_ACT_WIP;
        end
      end
      TCP_ACT_BUSY: begin
        if (rf_cmd_done || (rf_cmd_bad && rf_crc_done)) begin
          act_d = TCP_ACT_IDLE;
        end
      end
      TCP_ACT_WIP: begin
        if (rf_answer_start) begin
          act_d = TCP_ACT_IDLE;
        end
      end
      default: begin
        act_d = TCP_ACT_IDLE;
      end
    endcase
    if (!field_s) begin
      act_d = TCP_ACT_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      act_q <= TCP_ACT_IDLE;
    end else begin
      act_q <= act_d;
    end
  end

  // Mode follows config live, so a mode change drops a stale indication
  always_comb begin
    rf_activity_output_o = 1'b0;
    rf_activity_output_oe = 1'b0;
    if (i2c_cmd_active) begin
      rf_activity_output_oe = 1'b0;
    end else if (act_q == TCP_ACT_BUSY && !config_q[TCP_CFG_MODE_BIT]) begin
      rf_activity_output_oe = 1'b1;
    end else if (act_q == TCP_ACT_WIP && config_q[TCP_CFG_MODE_BIT]) begin
      rf_activity_output_oe = 1'b1;
    end
  end

  assign harvest_out_en = control_hon_q && power_s && current_s;

  a_lock_blocks: assert property (@(posedge clock) disable iff (!rst_n)
    (i2c_mem_write && wlock_q[i2c_mem_addr[8:7]]) |-> !i2c_mem_write_allow)
    else $error("write to locked sector allowed");
  a_lock_pwd: assert property (@(posedge clock) disable iff (!rst_n)
    (i2c_wr && sel_wlock_lo && !i2c_password_ok) |=> $stable(wlock_q))
    else $error("lock changed without password");
  a_done_clear: assert property (@(posedge clock) disable iff (!rst_n)
    write_cycle_start |=> !done_q)
    else $error("write done not cleared");
  a_done_set: assert property (@(posedge clock) disable iff (!rst_n)
    (write_cycle_ok && !write_cycle_start) |=> done_q)
    else $error("write done not set");
  a_busy_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (act_q == TCP_ACT_IDLE && rf_sof && field_s && !config_q[TCP_CFG_MODE_BIT])
    ##1 (!i2c_cmd_active && !config_q[TCP_CFG_MODE_BIT]) |-> rf_activity_output_oe)
    else $error("busy not driven after start of frame");
  a_field_drop: assert property (@(posedge clock) disable iff (!rst_n)
    !field_s |=> act_q == TCP_ACT_IDLE)
    else $error("activity held after field loss");
  a_i2c_release: assert property (@(posedge clock) disable iff (!rst_n)
    i2c_cmd_active |-> !rf_activity_output_oe)
    else $error("activity driven during I2C command");
  a_harvest_gate: assert property (@(posedge clock) disable iff (!rst_n)
    harvest_out_en |-> control_hon_q && power_s && current_s)
    else $error("harvest enabled while off");
  a_rf_field_one: assert property (@(posedge clock) disable iff (!rst_n)
    (rf_req.valid && rf_req.cmd == TCP_RF_READ_CONTROL) |=> rf_rdata_q[1] && !rf_rdata_q[7])
    else $error("RF control read wrong");
  a_power_load: assert property (@(posedge clock) disable iff (!rst_n)
    init_q |=> control_hon_q == !$past(config_q[TCP_CFG_HDEF_BIT]))
    else $error("harvest-on not loaded from default");
endmodule
`default_nettype wire

// ### design/tcp_pkg.sv
// Package for the tag configuration and protection register logic.
// Assumes one 125 MHz clock and a synchronous active-low reset.
`default_nettype none
package tcp_pkg;
  localparam logic [11:0] TCP_ADDR_WLOCK_LO = 12'h800;
  localparam logic [11:0] TCP_ADDR_WLOCK_HI = 12'h801;
  localparam logic [11:0] TCP_ADDR_CONFIG = 12'h910;
  localparam logic [11:0] TCP_ADDR_CONTROL = 12'h920;
  localparam logic [15:0] TCP_WLOCK_RESET = 16'h0000;
  localparam logic [7:0] TCP_CONFIG_DELIVERY = 8'hF4;
  localparam int TCP_CFG_MODE_BIT = 3;
  localparam int TCP_CFG_HDEF_BIT = 2;
  localparam int TCP_CTL_DONE_BIT = 7;
  localparam int TCP_CTL_FIELD_BIT = 1;
  localparam int TCP_CTL_HON_BIT = 0;
  localparam int TCP_SECTOR_COUNT = 4;
  localparam logic [7:0] TCP_HARV_CFG_MASK = 8'h07;
  localparam logic [7:0] TCP_MODE_CFG_MASK = 8'h08;
  localparam logic [8:0] TCP_SECTOR_SIZE_LOG2 = 9'h007;
  typedef enum logic [2:0] {
    TCP_RF_NONE = 3'b000,
    TCP_RF_READ_CONFIG = 3'b001,
    TCP_RF_WRITE_HARVEST = 3'b010,
    TCP_RF_WRITE_OUTPUT = 3'b011,
    TCP_RF_READ_CONTROL = 3'b100,
    TCP_RF_SET_HARVEST = 3'b101
  } tcp_rf_cmd_e;
  typedef enum logic [1:0] {
    TCP_ACT_IDLE = 2'b00,
    TCP_ACT_BUSY = 2'b01,
    TCP_ACT_WIP = 2'b10
  } tcp_act_e;
  // One I2C byte access as the protocol engine presents it
  typedef struct packed {
    logic valid;
    logic write;
    logic chip_enable_select_bit;
    logic [11:0] addr;
    logic [7:0] wdata;
  } tcp_i2c_req_s;
  // One RF configuration command as the RF engine presents it
  typedef struct packed {
    logic valid;
    tcp_rf_cmd_e cmd;
    logic [7:0] wdata;
  } tcp_rf_req_s;
endpackage
`default_nettype wire

// ### design/tcp_sync2.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the level is slow compared to the 125 MHz clock.
`default_nettype none
module tcp_sync2 (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end
endmodule
`default_nettype wire

// ### test/tcp_host_model.sv
// Host side of the activity pin: pull-up on the open-drain line.
// Assumes the design drives 0 while its output enable is high.
`default_nettype none
module tcp_host_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic line_lvl,
  output var int low_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released line floats up to the pull-up level, never holds the last value
  assign line_lvl = pin_oe ? pin_o : 1'b1;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      low_cycles <= 0;
    end else if (!line_lvl) begin
      low_cycles <= low_cycles + 1;
    end
  end
endmodule
`default_nettype wire

// ### test/tcp_regs_tb_top.sv
// Self-checking bench for the tag register logic.
// Assumes host model on the activity pin; pins settle in 2 cycles.
`default_nettype none
module tcp_regs_tb_top import tcp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  tcp_i2c_req_s i2c_req = '0;
  tcp_rf_req_s rf_req = '0;
  logic pw_ok = 1'b0, cmd_act = 1'b0, mem_wr = 1'b0, bad = 1'b0;
  logic field = 1'b0, pwr = 1'b0, cur = 1'b0;
  logic [8:0] mem_addr = '0;
  logic [6:0] ev = '0;
  logic allow, ack, act_o, act_oe, hout, line_lvl;
  logic [7:0] i2c_rd, rf_rd, cfg;
  logic [1:0] sink;
  logic [15:0] wlock;
  int fail_count = 0;
  int checks_done = 0;
  int low_cycles;
  always #4 clock = ~clock;
  tcp_regs dut (.clock(clock), .rst_n(rst_n), .i2c_req(i2c_req), .i2c_password_ok(pw_ok),
    .i2c_cmd_active(cmd_act), .i2c_mem_addr(mem_addr), .i2c_mem_write(mem_wr),
    .i2c_mem_write_allow(allow), .i2c_rdata_q(i2c_rd), .i2c_ack(ack), .rf_req(rf_req),
    .rf_rdata_q(rf_rd), .rf_sof(ev[0]), .rf_crc_done(ev[1]), .rf_cmd_bad(bad),
    .rf_cmd_done(ev[2]), .rf_write_start(ev[3]), .rf_answer_start(ev[4]),
    .write_cycle_start(ev[5]), .write_cycle_ok(ev[6]), .rf_field_pin(field),
    .power_ok_pin(pwr), .current_ok_pin(cur), .rf_activity_output_o(act_o),
    .rf_activity_output_oe(act_oe), .harvest_out_en(hout), .sink_level(sink),
    .config_q(cfg), .wlock_q(wlock));
  tcp_host_model host (.clock(clock), .rst_n(rst_n), .pin_o(act_o), .pin_oe(act_oe),
    .line_lvl(line_lvl), .low_cycles(low_cycles));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Writes leave the read data alone, so only reads compare it
  task automatic acc(input logic w, ce, input logic [11:0] a, input logic [7:0] d,
                     input logic ea, input logic [7:0] ed);
    logic ak;
    @(posedge clock);
    i2c_req <= {1'b1, w, ce, a, d};
    #1 ak = ack;
    @(posedge clock);
    i2c_req <= '0;
    #1 chk(16'(ak), 16'(ea));
    if (!w) chk(16'(i2c_rd), 16'(ed));
  endtask
  task automatic rf(input tcp_rf_cmd_e c, input logic [7:0] d, input logic [7:0] ed);
    @(posedge clock);
    rf_req <= {1'b1, c, d};
    @(posedge clock);
    rf_req <= '0;
    #1 if (c == TCP_RF_READ_CONFIG || c == TCP_RF_READ_CONTROL) chk(16'(rf_rd), 16'(ed));
  endtask
  // One-cycle event, then the pulled-up line level is judged
  task automatic pulse(input int i, input logic eoe);
    @(posedge clock);
    ev <= 7'h01 << i;
    @(posedge clock);
    ev <= '0;
    #1 chk(16'(line_lvl), 16'(!eoe));
  endtask
  task automatic pins(input logic f, p, c);
    @(posedge clock);
    field <= f;
    pwr <= p;
    cur <= c;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic mchk(input logic [1:0] s, input logic e);
    @(posedge clock);
    mem_addr <= {s, 7'h55};
    mem_wr <= 1'b1;
    #1 chk(16'(allow), 16'(e));
  endtask
  task automatic t_reset();
    chk(wlock, 16'h0000);
    chk(16'(cfg), 16'h00F4);
    acc(1'b0, 1'b1, 12'h800, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 1'b1, 12'h801, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 1'b1, 12'h920, 8'h00, 1'b1, 8'h00);
  endtask
  task automatic t_lock();
    logic [7:0] v;
    v = 8'hF5;
    acc(1'b1, 1'b1, 12'h800, 8'h0F, 1'b1, 8'h00);
    chk(wlock, 16'h0000);
    @(posedge clock) pw_ok <= 1'b1;
    acc(1'b1, 1'b0, 12'h800, 8'h0F, 1'b0, 8'h00);
    chk(wlock, 16'h0000);
    acc(1'b1, 1'b1, 12'h800, v, 1'b1, 8'h00);
    acc(1'b1, 1'b1, 12'h801, 8'hAB, 1'b1, 8'h00);
    chk(wlock, 16'hABF5);
    for (int s = 0; s < 4; s++) mchk(2'(s), !v[s]);
    acc(1'b0, 1'b0, 12'h800, 8'h00, 1'b0, 8'h00);
    acc(1'b0, 1'b1, 12'h800, 8'h00, 1'b1, v);
    acc(1'b1, 1'b1, 12'h800, 8'h00, 1'b1, 8'h00);
    mchk(2'h0, 1'b1);
    @(posedge clock) pw_ok <= 1'b0;
  endtask
  task automatic t_cfg();
    acc(1'b1, 1'b1, 12'h910, 8'hF0, 1'b1, 8'h00);
    acc(1'b0, 1'b1, 12'h910, 8'h00, 1'b1, 8'hF0);
    acc(1'b1, 1'b1, 12'h910, 8'hFB, 1'b1, 8'h00);
    chk(16'(sink), 16'h0003);
    acc(1'b1, 1'b1, 12'h920, 8'hFF, 1'b1, 8'h00);
    acc(1'b0, 1'b1, 12'h920, 8'h00, 1'b1, 8'h01);
    pins(1'b0, 1'b1, 1'b1);
    chk(16'(hout), 16'h0001);
    pins(1'b0, 1'b0, 1'b1);
    chk(16'(hout), 16'h0000);
    pins(1'b0, 1'b1, 1'b0);
    chk(16'(hout), 16'h0000);
    pins(1'b1, 1'b1, 1'b1);
    acc(1'b1, 1'b1, 12'h920, 8'h00, 1'b1, 8'h00);
    chk(16'(hout), 16'h0000);
    acc(1'b0, 1'b1, 12'h920, 8'h00, 1'b1, 8'h02);
  endtask
  task automatic t_rf();
    acc(1'b1, 1'b1, 12'h910, 8'hF8, 1'b1, 8'h00);
    rf(TCP_RF_WRITE_HARVEST, 8'h07, 8'h00);
    rf(TCP_RF_READ_CONFIG, 8'h00, 8'hFF);
    rf(TCP_RF_WRITE_OUTPUT, 8'h00, 8'h00);
    rf(TCP_RF_READ_CONFIG, 8'h00, 8'hF7);
    rf(TCP_RF_WRITE_HARVEST, 8'h08, 8'h00);
    rf(TCP_RF_READ_CONFIG, 8'h00, 8'hF0);
    pulse(5, 1'b0);
    pulse(6, 1'b0);
    acc(1'b0, 1'b1, 12'h920, 8'h00, 1'b1, 8'h82);
    rf(TCP_RF_SET_HARVEST, 8'h01, 8'h00);
    pins(1'b0, 1'b1, 1'b1);
    rf(TCP_RF_READ_CONTROL, 8'h00, 8'h03);
    rf(TCP_RF_SET_HARVEST, 8'h00, 8'h00);
    rf(TCP_RF_READ_CONTROL, 8'h00, 8'h02);
    pulse(5, 1'b0);
    acc(1'b0, 1'b1, 12'h920, 8'h00, 1'b1, 8'h00);
  endtask
  task automatic t_act();
    pins(1'b1, 1'b1, 1'b1);
    pulse(0, 1'b1);
    pulse(1, 1'b1);
    pulse(2, 1'b0);
    chk(16'(low_cycles > 0), 16'h0001);
    pulse(0, 1'b1);
    @(posedge clock) bad <= 1'b1;
    pulse(1, 1'b0);
    @(posedge clock) bad <= 1'b0;
    pulse(0, 1'b1);
    pins(1'b0, 1'b1, 1'b1);
    chk(16'(line_lvl), 16'h0001);
    pins(1'b1, 1'b1, 1'b1);
    pulse(0, 1'b1);
    @(posedge clock) cmd_act <= 1'b1;
    @(posedge clock) #1 chk(16'(line_lvl), 16'h0001);
    @(posedge clock) cmd_act <= 1'b0;
    pulse(2, 1'b0);
    acc(1'b1, 1'b1, 12'h910, 8'hF8, 1'b1, 8'h00);
    pulse(0, 1'b0);
    pulse(2, 1'b0);
    pulse(3, 1'b1);
    @(posedge clock) cmd_act <= 1'b1;
    @(posedge clock) #1 chk(16'(line_lvl), 16'h0001);
    @(posedge clock) cmd_act <= 1'b0;
    @(posedge clock) #1 chk(16'(line_lvl), 16'h0000);
    pulse(4, 1'b0);
  endtask
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    t_reset();
    t_lock();
    t_cfg();
    t_rf();
    t_act();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
